// [logic/stepper_phase_sequencer.v]
`include "stepper_seq_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module stepper_phase_sequencer (
  // clock and reset
  input wire REF_CLK,
  input wire RESET,
  input wire CLK_EN,
  // host control
  input wire STEP_IN,
  input wire EXCITATION_SELECT,
  input wire EDGE_SELECT,
  input wire DIRECTION_SELECT,
  input wire SYSTEM_RESET_N,
  input wire OUTPUT_ENABLE,
  // protection detectors
  input wire OPEN_DETECT,
  input wire OVERCURRENT_DETECT,
  input wire OVERHEAT_DETECT,
  // winding drives
  output reg FIRST_WINDING_OUT,
  output reg FIRST_WINDING_INVERSE_OUT,
  output reg SECOND_WINDING_OUT,
  output reg SECOND_WINDING_INVERSE_OUT,
  // fault reporting
  output reg PROTECT_FLAG_N,
  output reg [1:0] PROTECT_LEVEL_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // pattern lookup: even positions are two-winding states

  function [3:0] pattern;
    input [`POS_W-1:0] pos;
    begin
      case (pos)
        3'h0: begin
          pattern = 4'h9; // a + b_n
        end
        3'h1: begin
          pattern = 4'h8; // a
        end
        3'h2: begin
          pattern = 4'hA; // a + b
        end
        3'h3: begin
          pattern = 4'h2; // b
        end
        3'h4: begin
          pattern = 4'h6; // a_n + b
        end
        3'h5: begin
          pattern = 4'h4; // a_n
        end
        3'h6: begin
          pattern = 4'h5; // a_n + b_n
        end
        default: begin
          pattern = 4'h1; // b_n
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // half positions covered by one step

  function [`POS_W-1:0] step_size;
    input half_mode;
    input odd_pos;
    begin
      if (half_mode) begin
        step_size = `STEP_HALF;
      end else if (odd_pos) begin
        // odd spot left by half-step snaps to the next two-winding state
        step_size = `STEP_HALF;
      end else begin
        step_size = `STEP_FULL;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fault level priority: overheat, then overcurrent, then open terminal

  function [1:0] level_code;
    input heat;
    input over;
    input open_hit;
    begin
      if (heat) begin
        level_code = `LVL_OVERHEAT;
      end else if (over) begin
        level_code = `LVL_OVERCUR;
      end else if (open_hit) begin
        level_code = `LVL_OPEN;
      end else begin
        level_code = `LVL_NONE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // step edge detection

  reg step_d_r;
  reg [`POS_W-1:0] pos_r;
  reg [`POS_W-1:0] pos_nxt;
  reg [`POS_W-1:0] delta;
  reg [`POS_W-1:0] pos_fwd;
  reg [`POS_W-1:0] pos_rev;
  reg rise;
  reg fall;
  reg advance;
  reg hold;
  wire [3:0] pat;
  reg first_nxt;
  reg first_inv_nxt;
  reg second_nxt;
  reg second_inv_nxt;
  reg flag_nxt;
  reg [1:0] level_nxt;

  always @* begin
    rise = 1'b0;
    if (STEP_IN && !step_d_r) begin
      rise = 1'b1;
    end
  end

  always @* begin
    fall = 1'b0;
    if (!STEP_IN && step_d_r) begin
      fall = 1'b1;
    end
  end

  always @* begin
    advance = 1'b0;
    if (rise) begin
      advance = 1'b1;
    end else if (fall && !EDGE_SELECT) begin
      // both-edge mode doubles the step rate for a given pulse frequency
      advance = 1'b1;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      step_d_r <= 1'b0;
    end else if (CLK_EN) begin
      // sampled in system reset too, so a held level is no edge later
      step_d_r <= STEP_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // position update

  always @* begin
    delta = step_size(EXCITATION_SELECT, pos_r[0]);
  end

  always @* begin
    pos_fwd = pos_r + delta;
  end

  always @* begin
    pos_rev = pos_r - delta;
  end

  always @* begin
    hold = 1'b0;
    if (!SYSTEM_RESET_N) begin
      hold = 1'b1;
    end
  end

  always @* begin
    pos_nxt = pos_r;
    if (hold) begin
      pos_nxt = `POS_INIT;
    end else if (advance) begin
      if (DIRECTION_SELECT) begin
        pos_nxt = pos_rev;
      end else begin
        pos_nxt = pos_fwd;
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      pos_r <= `POS_INIT;
    end else if (CLK_EN) begin
      // disable does not stop stepping, so timing is kept
      pos_r <= pos_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // winding drives, one register stage

  assign pat = pattern(pos_r);

  always @* begin
    first_nxt = 1'b0;
    first_inv_nxt = 1'b0;
    second_nxt = 1'b0;
    second_inv_nxt = 1'b0;
    if (OUTPUT_ENABLE) begin
      first_nxt = pat[`PH_A];
      first_inv_nxt = pat[`PH_A_N];
      second_nxt = pat[`PH_B];
      second_inv_nxt = pat[`PH_B_N];
    end else begin
      // position keeps moving; only the windings go dark
      first_nxt = 1'b0;
      first_inv_nxt = 1'b0;
      second_nxt = 1'b0;
      second_inv_nxt = 1'b0;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      FIRST_WINDING_OUT <= 1'b0;
    end else if (CLK_EN) begin
      FIRST_WINDING_OUT <= first_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      FIRST_WINDING_INVERSE_OUT <= 1'b0;
    end else if (CLK_EN) begin
      FIRST_WINDING_INVERSE_OUT <= first_inv_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      SECOND_WINDING_OUT <= 1'b0;
    end else if (CLK_EN) begin
      SECOND_WINDING_OUT <= second_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      SECOND_WINDING_INVERSE_OUT <= 1'b0;
    end else if (CLK_EN) begin
      SECOND_WINDING_INVERSE_OUT <= second_inv_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault reporting

  always @* begin
    flag_nxt = 1'b1;
    if (OVERCURRENT_DETECT || OVERHEAT_DETECT) begin
      flag_nxt = 1'b0;
    end
  end

  always @* begin
    // open terminal shows on the level output only
    level_nxt = level_code(OVERHEAT_DETECT, OVERCURRENT_DETECT, OPEN_DETECT);
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      PROTECT_FLAG_N <= 1'b1;
    end else if (CLK_EN) begin
      PROTECT_FLAG_N <= flag_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      PROTECT_LEVEL_OUT <= `LVL_NONE;
    end else if (CLK_EN) begin
      PROTECT_LEVEL_OUT <= level_nxt;
    end
  end

endmodule

`default_nettype wire

// [logic/stepper_seq_consts.vh]
`ifndef STEPPER_SEQ_CONSTS_VH
`define STEPPER_SEQ_CONSTS_VH

// phase position counter, eight half-step positions
`define POS_W 3
`define POS_INIT 3'h0
// half positions moved by one step in each excitation mode
`define STEP_HALF 3'h1
`define STEP_FULL 3'h2
// phase output bit positions in the pattern word {a, a_n, b, b_n}
`define PH_A 3
`define PH_A_N 2
`define PH_B 1
`define PH_B_N 0
`define PH_OFF 4'h0
// fault level codes on the four-level fault output
`define LVL_NONE 2'h0
`define LVL_OPEN 2'h1
`define LVL_OVERCUR 2'h2
`define LVL_OVERHEAT 2'h3

`endif

// [verif/seq_props.sv]
`timescale 1ns/100ps
`default_nettype none
module seq_props (
  // sequencer ports, as seen from outside
  input wire logic REF_CLK, RESET, CLK_EN, STEP_IN, EXCITATION_SELECT,
  input wire logic EDGE_SELECT, SYSTEM_RESET_N, OUTPUT_ENABLE, OPEN_DETECT,
  input wire logic OVERCURRENT_DETECT, OVERHEAT_DETECT, PROTECT_FLAG_N,
  input wire logic FIRST_WINDING_OUT, FIRST_WINDING_INVERSE_OUT,
  input wire logic SECOND_WINDING_OUT, SECOND_WINDING_INVERSE_OUT,
  input wire logic [1:0] PROTECT_LEVEL_OUT
);
  wire [3:0] w = {FIRST_WINDING_OUT, FIRST_WINDING_INVERSE_OUT,
    SECOND_WINDING_OUT, SECOND_WINDING_INVERSE_OUT};
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // enable steady over two edges, so only a step can move the pattern
  sequence s_calm;
    CLK_EN && OUTPUT_ENABLE && SYSTEM_RESET_N && $past(CLK_EN & OUTPUT_ENABLE);
  endsequence
  // windings show a new position one edge after the position register
  sequence s_held;
    CLK_EN && OUTPUT_ENABLE;
  endsequence
  a_rise_moves: assert property (
    s_calm ##0 $rose(STEP_IN) ##1 s_held |=> !$stable(w))
    else $error("no step");
  a_fall_ignored: assert property (
    s_calm ##0 (EDGE_SELECT && $fell(STEP_IN)) ##1 s_held |=> $stable(w))
    else $error("fall stepped");
  a_fall_moves: assert property (
    s_calm ##0 (!EDGE_SELECT && $fell(STEP_IN)) ##1 s_held
    |=> !$stable(w))
    else $error("fall lost");
  a_full_pairs: assert property (
    s_calm ##0 ($rose(STEP_IN) && !EXCITATION_SELECT) ##1 s_held
    |=> $countones(w) == 2)
    else $error("full step pattern");
  a_reset_init: assert property (
    (CLK_EN && OUTPUT_ENABLE && !SYSTEM_RESET_N)[*2] |=> w == 4'h9)
    else $error("initial pattern");
  a_enable_off: assert property (
    CLK_EN && !OUTPUT_ENABLE |=> w == 4'h0) else $error("windings on");
  a_flag_fault: assert property (
    CLK_EN |=> PROTECT_FLAG_N == !$past(OVERCURRENT_DETECT | OVERHEAT_DETECT))
    else $error("fault flag");
  a_level_code: assert property (
    CLK_EN |=> PROTECT_LEVEL_OUT == $past(OVERHEAT_DETECT ? 2'h3 :
    {OVERCURRENT_DETECT, !OVERCURRENT_DETECT & OPEN_DETECT}))
    else $error("fault level");
endmodule
bind stepper_phase_sequencer seq_props props_u (.*);
`default_nettype wire

// [verif/step_host.sv]
`timescale 1ns/100ps
`default_nettype none
module step_host (
  input wire logic clk,
  output var logic step = 1'h0
);
  // a quiet cycle after each edge keeps steps spaced, config steady
  task toggle;
    @(posedge clk) step <= ~step;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst, xs, es, ds, srn, oe, oc, oh, op;
  logic ce = 1'h1;
  wire stp, fl;
  wire [1:0] lv;
  wire [3:0] w;
  int mismatches, total_checks;
  step_host host_u (.clk(clk), .step(stp));
  stepper_phase_sequencer dut_u (.REF_CLK(clk), .RESET(rst), .CLK_EN(ce),
    .STEP_IN(stp), .EXCITATION_SELECT(xs), .EDGE_SELECT(es),
    .DIRECTION_SELECT(ds), .SYSTEM_RESET_N(srn), .OUTPUT_ENABLE(oe),
    .OPEN_DETECT(op), .OVERCURRENT_DETECT(oc), .OVERHEAT_DETECT(oh),
    .FIRST_WINDING_OUT(w[3]), .FIRST_WINDING_INVERSE_OUT(w[2]),
    .SECOND_WINDING_OUT(w[1]), .SECOND_WINDING_INVERSE_OUT(w[0]),
    .PROTECT_FLAG_N(fl), .PROTECT_LEVEL_OUT(lv));
  initial forever #10 clk = ~clk;
  // word is {flag, level, windings}, checked one edge on
  task chk(input logic [6:0] e);
    @(posedge clk) #1;
    total_checks++;
    if ({fl, lv, w} !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t bad outputs", $time);
    end
  endtask
  task t_full;
    host_u.toggle();
    chk(7'h4A);
    host_u.toggle();
    chk(7'h4A);
  endtask
  task t_half;
    @(posedge clk) {xs, ds, es} <= 3'h6;
    host_u.toggle();
    chk(7'h48);
    @(posedge clk) xs <= 1'h0;
    host_u.toggle();
    chk(7'h49);
    host_u.toggle();
    chk(7'h45);
  endtask
  task t_enable;
    @(posedge clk) oe <= 1'h0;
    chk(7'h40);
    host_u.toggle();
    @(posedge clk) oe <= 1'h1;
    chk(7'h46);
  endtask
  task t_sysreset;
    @(posedge clk) srn <= 1'h0;
    host_u.toggle();
    @(posedge clk) srn <= 1'h1;
    chk(7'h49);
  endtask
  // frozen clock enable holds everything; the missed edge lands on resume
  task t_freeze;
    @(posedge clk) ce <= 1'h0;
    host_u.toggle();
    chk(7'h49);
    @(posedge clk) ce <= 1'h1;
    chk(7'h49);
    chk(7'h45);
  endtask
  task t_faults;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) {oh, oc, op} <= i[2:0];
      chk({!(i[2] | i[1]), i[2] ? 2'h3 : {i[1], !i[1] & i[0]}, 4'h5});
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    {rst, xs, es, ds, srn, oe, oc, oh, op} = 9'h158;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(7'h49);
    t_full();
    t_half();
    t_enable();
    t_sysreset();
    t_freeze();
    t_faults();
    complete_run();
  end
endmodule
`default_nettype wire
